// file: hdl/clock_generator_config.v
/*
 Clock generator configuration: AXI4-Lite register file, start-up counters,
 frequency meter, PLL setup and clock source/prescaler selection.
 Assumes slow, main and PLL clocks arrive as asynchronous pins sampled on aclk,
 each much slower than aclk.
*/
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
//
// Summary of operation
// [R01] Peripheral status bits mirror running peripheral clocks
// [R02] USB PLL lock only after start-up elapses
// [R03] USB PLL start-up is count times 8
// [R04] Bias enable gates high-speed USB operation
// [R05] Bias start-up is count slow cycles
// [R06] Oscillator stable only after start-up elapses
// [R07] Software never sets enable and bypass together
// [R08] Bypass sets oscillator stable flag immediately
// [R09] Clearing enable and bypass clears stable
// [R10] Oscillator start-up is count times 8
// [R11] Meter counts main cycles in 16 slow
// [R12] Frequency valid only after enable and count
// [R13] PLL divider: 0 off, 1 bypass, else divide
// [R14] PLL lock after count following each write
// [R15] Multiplier zero stops PLL, else times plus one
// [R16] Software programs PLL range to match output
// [R17] Source select: slow, main, PLL, reserved
// [R18] Prescaler divides by two to the field
// [R19] Master division by one, two or four
// [R20] Master ready flag after each reconfiguration
// [R21] Disabling PLLs clears lock until recount
// [R22] Software avoids reserved encodings
// [R23] Writes to read-only registers are ignored
`timescale 1ns/1ps
`default_nettype none
`include "clock_generator_config_map.vh"
module clock_generator_config #(
    parameter ADDR_W = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire slow_clk_pin,
    input wire main_clk_pin,
    input wire pll_clk_pin,
    input wire [31:0] periph_clock_bit,
    output reg usb_pll_enable,
    output reg usb_bias_enable,
    output reg usb_bias_ready,
    output reg usb_hs_allowed,
    output reg main_osc_enable,
    output reg main_osc_bypass,
    output reg pll_enable,
    output reg [11:0] pll_mul_factor,
    output reg [1:0] pll_freq_range,
    output reg pll_ref_tick,
    output wire proc_clk_tick,
    output wire master_clk_tick,
    output wire [1:0] prog_clk_tick
);
    localparam [2:0] FM_IDLE = 3'b001;
    localparam [2:0] FM_ALIGN = 3'b010;
    localparam [2:0] FM_COUNT = 3'b100;

    function [31:0] merge_bytes;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] strb;
        integer i;
        begin
            merge_bytes = old_val;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge_bytes[i*8 +: 8] = new_val[i*8 +: 8];
                end
            end
        end
    endfunction

    function mapped;
        input [7:0] a;
        begin
            mapped = (a == `OFS_PERIPH_STATE) || (a == `OFS_USB_PLL_BIAS) ||
                (a == `OFS_MAIN_OSC) || (a == `OFS_FREQ_METER) ||
                (a == `OFS_PLL_SETUP) || (a == `OFS_MASTER_CLK) ||
                (a == `OFS_OUT_CLK0) || (a == `OFS_OUT_CLK1) ||
                (a == `OFS_CLK_STATUS);
        end
    endfunction

    function pick_source;
        input [1:0] clock_source_select;
        input slow_t;
        input main_t;
        input pll_t;
        begin
            case (clock_source_select)
                `CSS_SLOW: pick_source = slow_t;
                `CSS_MAIN: pick_source = main_t;
                `CSS_PLL: pick_source = pll_t;
                default: pick_source = 1'b0;
            endcase
        end
    endfunction

    // Pin synchronisers: slow, main, PLL
    reg [2:0] sync1_ff, sync2_ff, sync3_ff, level_ff;
    wire [2:0] agree = ~(sync2_ff ^ sync3_ff);
    wire [2:0] rise_tick = agree & sync3_ff & ~level_ff;
    wire slow_tick = rise_tick[0];
    wire main_tick = rise_tick[1];
    wire pll_tick = rise_tick[2];

    always @(posedge aclk) begin
        if (!aresetn) begin
            sync1_ff <= 3'b000;
            sync2_ff <= 3'b000;
            sync3_ff <= 3'b000;
            level_ff <= 3'b000;
        end else begin
            sync1_ff <= {pll_clk_pin, main_clk_pin, slow_clk_pin};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            level_ff <= (agree & sync3_ff) | (~agree & level_ff);
        end
    end

    // AXI4-Lite write path
    reg aw_got_ff, w_got_ff;
    reg [7:0] waddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;
    wire do_write = aw_got_ff && w_got_ff;
    wire [7:0] wr_ofs = {waddr_ff[7:2], 2'b00};

    assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
    assign s_axi_wready = !w_got_ff && !s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            waddr_ff <= 8'h00;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff <= 1'b1;
                waddr_ff <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(wr_ofs) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Writable registers; read-only offsets fall through unchanged
    reg [31:0] uckr_ff, mor_ff, pllr_ff, mckr_ff, pck0_ff, pck1_ff; // R23
    wire wr_uckr = do_write && (wr_ofs == `OFS_USB_PLL_BIAS);
    wire wr_mor = do_write && (wr_ofs == `OFS_MAIN_OSC);
    wire wr_pllr = do_write && (wr_ofs == `OFS_PLL_SETUP);
    wire wr_mckr = do_write && (wr_ofs == `OFS_MASTER_CLK);
    wire wr_pck0 = do_write && (wr_ofs == `OFS_OUT_CLK0);
    wire wr_pck1 = do_write && (wr_ofs == `OFS_OUT_CLK1);

    always @(posedge aclk) begin
        if (!aresetn) begin
            uckr_ff <= `RST_USB_PLL_BIAS;
            mor_ff <= `RST_MAIN_OSC;
            pllr_ff <= `RST_PLL_SETUP;
            mckr_ff <= `RST_MASTER_CLK;
            pck0_ff <= `RST_OUT_CLK;
            pck1_ff <= `RST_OUT_CLK;
        end else begin
            if (wr_uckr)
                uckr_ff <= merge_bytes(uckr_ff, wdata_ff, wstrb_ff) & `MASK_USB_PLL_BIAS;
            if (wr_mor)
                mor_ff <= merge_bytes(mor_ff, wdata_ff, wstrb_ff) & `MASK_MAIN_OSC;
            if (wr_pllr)
                pllr_ff <= merge_bytes(pllr_ff, wdata_ff, wstrb_ff) & `MASK_PLL_SETUP;
            if (wr_mckr)
                mckr_ff <= merge_bytes(mckr_ff, wdata_ff, wstrb_ff) & `MASK_MASTER_CLK;
            if (wr_pck0)
                pck0_ff <= merge_bytes(pck0_ff, wdata_ff, wstrb_ff) & `MASK_OUT_CLK;
            if (wr_pck1)
                pck1_ff <= merge_bytes(pck1_ff, wdata_ff, wstrb_ff) & `MASK_OUT_CLK;
        end
    end

    wire upll_en = uckr_ff[`UPLL_EN_BIT];
    wire bias_en = uckr_ff[`BIAS_EN_BIT];
    wire osc_en = mor_ff[`OSC_EN_BIT];
    wire osc_byp = mor_ff[`OSC_BYP_BIT];
    wire [7:0] pll_div = pllr_ff[`PLL_DIV_MSB:`PLL_DIV_LSB];
    wire [10:0] pll_mul = pllr_ff[`PLL_MUL_MSB:`PLL_MUL_LSB];
    wire [6:0] upll_target = {uckr_ff[`UPLL_CNT_MSB:`UPLL_CNT_LSB], `STARTUP_SHIFT}; // R03
    wire [3:0] bias_target = uckr_ff[`BIAS_CNT_MSB:`BIAS_CNT_LSB]; // R05
    wire [10:0] osc_target = {mor_ff[`OSC_CNT_MSB:`OSC_CNT_LSB], `STARTUP_SHIFT}; // R10
    wire [5:0] pll_target = pllr_ff[`PLL_CNT_MSB:`PLL_CNT_LSB];

    // Start-up counters on slow clock ticks
    reg [6:0] upll_cnt_ff;
    reg upll_lock_ff;
    reg [3:0] bias_cnt_ff;
    reg [10:0] osc_cnt_ff;
    reg osc_stable_ff;
    reg [5:0] pll_cnt_ff;
    reg pll_lock_ff;

    always @(posedge aclk) begin
        if (!aresetn || !upll_en) begin
            upll_cnt_ff <= 7'h00; // R21
            upll_lock_ff <= 1'b0;
        end else if (upll_cnt_ff >= upll_target) begin
            upll_lock_ff <= 1'b1; // R02
        end else if (slow_tick) begin
            upll_cnt_ff <= upll_cnt_ff + 1'b1;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn || !bias_en) begin
            bias_cnt_ff <= 4'h0;
            usb_bias_ready <= 1'b0;
        end else if (bias_cnt_ff >= bias_target) begin
            usb_bias_ready <= 1'b1; // R05
        end else if (slow_tick) begin
            bias_cnt_ff <= bias_cnt_ff + 1'b1;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn || (!osc_en && !osc_byp)) begin
            osc_cnt_ff <= 11'h000;
            osc_stable_ff <= 1'b0; // R09
        end else if (osc_byp) begin
            osc_stable_ff <= 1'b1; // R08
        end else if (osc_cnt_ff >= osc_target) begin
            osc_stable_ff <= 1'b1; // R06
        end else if (slow_tick) begin
            osc_cnt_ff <= osc_cnt_ff + 1'b1;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn || wr_pllr || pll_mul == 11'h000) begin
            pll_cnt_ff <= 6'h00; // R21
            pll_lock_ff <= 1'b0;
        end else if (pll_cnt_ff >= pll_target) begin
            pll_lock_ff <= 1'b1; // R14
        end else if (slow_tick) begin
            pll_cnt_ff <= pll_cnt_ff + 1'b1;
        end
    end

    // Main clock frequency meter
    reg [2:0] fm_state_ff;
    reg [3:0] win_cnt_ff;
    reg [15:0] acc_ff;
    reg [15:0] freq_count_ff;
    reg freq_valid_ff;

    always @(posedge aclk) begin
        if (!aresetn || !osc_stable_ff) begin
            fm_state_ff <= FM_IDLE;
            win_cnt_ff <= 4'h0;
            acc_ff <= 16'h0000;
            freq_count_ff <= 16'h0000;
            freq_valid_ff <= 1'b0; // R12
        end else begin
            case (fm_state_ff)
                FM_IDLE: begin
                    fm_state_ff <= FM_ALIGN;
                end
                FM_ALIGN: begin
                    if (slow_tick) begin
                        fm_state_ff <= FM_COUNT;
                        win_cnt_ff <= 4'h0;
                        acc_ff <= 16'h0000;
                    end
                end
                FM_COUNT: begin
                    if (slow_tick && win_cnt_ff == `FREQ_WINDOW_LAST) begin
                        freq_count_ff <= acc_ff + {15'h0000, main_tick}; // R11
                        freq_valid_ff <= 1'b1; // R12
                        acc_ff <= 16'h0000;
                        win_cnt_ff <= 4'h0;
                    end else begin
                        acc_ff <= acc_ff + {15'h0000, main_tick};
                        if (slow_tick)
                            win_cnt_ff <= win_cnt_ff + 1'b1;
                    end
                end
                default: begin
                    fm_state_ff <= FM_IDLE;
                end
            endcase
        end
    end

    // PLL input divider on main clock ticks
    reg [7:0] div_cnt_ff;
    always @(posedge aclk) begin
        if (!aresetn || wr_pllr) begin
            div_cnt_ff <= 8'h00;
            pll_ref_tick <= 1'b0;
        end else begin
            pll_ref_tick <= 1'b0;
            if (pll_div == 8'h01) begin
                pll_ref_tick <= main_tick; // R13
            end else if (pll_div != 8'h00 && main_tick) begin
                if (div_cnt_ff >= pll_div - 8'h01) begin
                    div_cnt_ff <= 8'h00;
                    pll_ref_tick <= 1'b1; // R13
                end else begin
                    div_cnt_ff <= div_cnt_ff + 8'h01;
                end
            end
        end
    end

    // Clock selection and division chains
    wire mck_src = pick_source(mckr_ff[`CSS_MSB:`CSS_LSB], slow_tick, main_tick, pll_tick); // R17
    wire pck0_src = pick_source(pck0_ff[`CSS_MSB:`CSS_LSB], slow_tick, main_tick, pll_tick); // R17
    wire pck1_src = pick_source(pck1_ff[`CSS_MSB:`CSS_LSB], slow_tick, main_tick, pll_tick); // R17
    wire [2:0] master_clock_division_log2 = {1'b0, mckr_ff[`MASTER_CLOCK_DIVISION_MSB:`MASTER_CLOCK_DIVISION_LSB]}; // R19

    clock_ratio_divider u_proc_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .src_tick(mck_src),
        .ratio_log2(mckr_ff[`CLOCK_PRESCALER_MSB:`CLOCK_PRESCALER_LSB]), // R18
        .restart(wr_mckr),
        .out_tick(proc_clk_tick)
    );
    clock_ratio_divider u_master_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .src_tick(proc_clk_tick),
        .ratio_log2(master_clock_division_log2), // R19
        .restart(wr_mckr),
        .out_tick(master_clk_tick)
    );
    clock_ratio_divider u_pck0_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .src_tick(pck0_src),
        .ratio_log2(pck0_ff[`CLOCK_PRESCALER_MSB:`CLOCK_PRESCALER_LSB]), // R18
        .restart(wr_pck0),
        .out_tick(prog_clk_tick[0])
    );
    clock_ratio_divider u_pck1_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .src_tick(pck1_src),
        .ratio_log2(pck1_ff[`CLOCK_PRESCALER_MSB:`CLOCK_PRESCALER_LSB]), // R18
        .restart(wr_pck1),
        .out_tick(prog_clk_tick[1])
    );

    // Master ready drops on reconfiguration unless a master tick falls in the write cycle; returns with the first new tick
    reg mck_ready_ff;
    always @(posedge aclk) begin
        if (!aresetn) begin
            mck_ready_ff <= 1'b1;
        end else if (master_clk_tick) begin
            mck_ready_ff <= 1'b1; // R20
        end else if (wr_mckr) begin
            mck_ready_ff <= 1'b0; // R20
        end
    end

    // Control outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            usb_pll_enable <= 1'b0;
            usb_bias_enable <= 1'b0;
            usb_hs_allowed <= 1'b0;
            main_osc_enable <= 1'b0;
            main_osc_bypass <= 1'b0;
            pll_enable <= 1'b0;
            pll_mul_factor <= 12'h000;
            pll_freq_range <= 2'b00;
        end else begin
            usb_pll_enable <= upll_en;
            usb_bias_enable <= bias_en;
            usb_hs_allowed <= bias_en; // R04
            main_osc_enable <= osc_en;
            main_osc_bypass <= osc_byp;
            pll_enable <= (pll_mul != 11'h000); // R15
            pll_mul_factor <= {1'b0, pll_mul} + 12'h001; // R15
            pll_freq_range <= pllr_ff[`PLL_RANGE_MSB:`PLL_RANGE_LSB];
        end
    end

    // AXI4-Lite read path
    reg [31:0] rd_mux;
    wire [7:0] rd_ofs = {s_axi_araddr[7:2], 2'b00};
    assign s_axi_arready = !s_axi_rvalid;

    always @* begin
        rd_mux = 32'h00000000;
        case (rd_ofs)
            `OFS_PERIPH_STATE: rd_mux = periph_clock_bit & `MASK_PERIPH_STATE; // R01
            `OFS_USB_PLL_BIAS: rd_mux = uckr_ff;
            `OFS_MAIN_OSC: rd_mux = mor_ff;
            `OFS_FREQ_METER: begin
                rd_mux[15:0] = freq_count_ff;
                rd_mux[`FREQ_VALID_BIT] = freq_valid_ff;
            end
            `OFS_PLL_SETUP: rd_mux = pllr_ff;
            `OFS_MASTER_CLK: rd_mux = mckr_ff;
            `OFS_OUT_CLK0: rd_mux = pck0_ff;
            `OFS_OUT_CLK1: rd_mux = pck1_ff;
            `OFS_CLK_STATUS: begin
                rd_mux[`ST_OSC_STABLE] = osc_stable_ff;
                rd_mux[`ST_PLL_LOCK] = pll_lock_ff;
                rd_mux[`ST_MCK_READY] = mck_ready_ff;
                rd_mux[`ST_UPLL_LOCK] = upll_lock_ff;
            end
            default: rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= mapped(rd_ofs) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: hdl/clock_generator_config_map.vh
/*
 Register map, field positions, reset values and masks of the clock
 generator configuration block. Definitions only; included by bare name.
*/
`ifndef CLOCK_GENERATOR_CONFIG_MAP_VH
`define CLOCK_GENERATOR_CONFIG_MAP_VH

`define OFS_PERIPH_STATE 8'h18
`define OFS_USB_PLL_BIAS 8'h1c
`define OFS_MAIN_OSC 8'h20
`define OFS_FREQ_METER 8'h24
`define OFS_PLL_SETUP 8'h28
`define OFS_MASTER_CLK 8'h30
`define OFS_OUT_CLK0 8'h40
`define OFS_OUT_CLK1 8'h44
`define OFS_CLK_STATUS 8'h68

`define RST_USB_PLL_BIAS 32'h00000000
`define RST_MAIN_OSC 32'h00000000
`define RST_PLL_SETUP 32'h00003f00
`define RST_MASTER_CLK 32'h00000000
`define RST_OUT_CLK 32'h00000000

`define MASK_USB_PLL_BIAS 32'hf1f10000
`define MASK_MAIN_OSC 32'h0000ff03
`define MASK_PLL_SETUP 32'h07ffffff
`define MASK_MASTER_CLK 32'h0000031f
`define MASK_OUT_CLK 32'h0000001f
`define MASK_PERIPH_STATE 32'hfffffffc

`define UPLL_EN_BIT 16
`define UPLL_CNT_LSB 20
`define UPLL_CNT_MSB 23
`define BIAS_EN_BIT 24
`define BIAS_CNT_LSB 28
`define BIAS_CNT_MSB 31
`define OSC_EN_BIT 0
`define OSC_BYP_BIT 1
`define OSC_CNT_LSB 8
`define OSC_CNT_MSB 15
`define FREQ_VALID_BIT 16
`define PLL_DIV_LSB 0
`define PLL_DIV_MSB 7
`define PLL_CNT_LSB 8
`define PLL_CNT_MSB 13
`define PLL_RANGE_LSB 14
`define PLL_RANGE_MSB 15
`define PLL_MUL_LSB 16
`define PLL_MUL_MSB 26
`define CSS_LSB 0
`define CSS_MSB 1
`define CLOCK_PRESCALER_LSB 2
`define CLOCK_PRESCALER_MSB 4
`define MASTER_CLOCK_DIVISION_LSB 8
`define MASTER_CLOCK_DIVISION_MSB 9
`define ST_OSC_STABLE 0
`define ST_PLL_LOCK 1
`define ST_MCK_READY 3
`define ST_UPLL_LOCK 6

`define CSS_SLOW 2'b00
`define CSS_MAIN 2'b01
`define CSS_PLL 2'b10
`define STARTUP_SHIFT 3'b000
`define FREQ_WINDOW_LAST 4'hf
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// file: hdl/clock_ratio_divider.v
/*
 Power-of-two tick divider used for prescaler and master division stages.
 Assumes src_tick is a one-cycle pulse on aclk, one per source period.
*/
`timescale 1ns/1ps
`default_nettype none
module clock_ratio_divider #(
    parameter CNT_W = 6
) (
    input wire aclk,
    input wire aresetn,
    input wire src_tick,
    input wire [2:0] ratio_log2,
    input wire restart,
    output reg out_tick
);
    reg [CNT_W-1:0] cnt_ff;
    wire [CNT_W-1:0] last_cnt;

    // Terminal count is 2^ratio - 1, at most 2^CNT_W - 1 (63 for ratio 6 and 7)
    assign last_cnt = ~({CNT_W{1'b1}} << ratio_log2);

    always @(posedge aclk) begin
        if (!aresetn || restart) begin
            cnt_ff <= {CNT_W{1'b0}};
            out_tick <= 1'b0;
        end else begin
            out_tick <= 1'b0;
            if (src_tick) begin
                if (cnt_ff >= last_cnt) begin
                    cnt_ff <= {CNT_W{1'b0}};
                    out_tick <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff + 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: verification/clock_generator_config_props.sv
/*
 Port assertions for clock_generator_config: bus handshakes and output relations.
 Assumes binding into every instance and the register map header on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "clock_generator_config_map.vh"
module clock_generator_config_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic usb_bias_enable,
    input wire logic usb_hs_allowed,
    input wire logic pll_enable,
    input wire logic [11:0] pll_mul_factor,
    input wire logic master_clk_tick
);
default clocking @(posedge aclk);
endclocking
default disable iff (!aresetn);
wr_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer not two cycles late");
rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid) else $error("arready wrong");
wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
err_data_a: assert property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 0)
    else $error("error read data not zero");
hs_follow_a: assert property (usb_hs_allowed == usb_bias_enable)
    else $error("high speed not following bias");
pll_active_a: assert property (pll_enable |-> pll_mul_factor > 12'h001)
    else $error("pll enabled with zero multiplier");
tick_pulse_a: assert property (master_clk_tick |=> !master_clk_tick)
    else $error("master tick too long");
endmodule
bind clock_generator_config clock_generator_config_props clock_generator_config_props_inst (.*);
`default_nettype wire

// file: verification/tb.sv
/*
 Self-checking bench for clock_generator_config over AXI4-Lite.
 Assumes the map header and design sources are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "clock_generator_config_map.vh"
module tb;
logic aclk = 0;
logic aresetn = 0;
logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
logic [3:0] s_axi_wstrb = 4'hf;
logic [31:0] s_axi_wdata = 0, periph_clock_bit = 0, s_axi_rdata, q;
logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
logic s_axi_rready = 0, slow_clk_pin = 0, main_clk_pin = 0, pll_clk_pin = 0;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic [1:0] s_axi_bresp, s_axi_rresp, pll_freq_range, prog_clk_tick, r;
logic usb_pll_enable, usb_bias_enable, usb_bias_ready, usb_hs_allowed, main_osc_enable;
logic main_osc_bypass, pll_enable, pll_ref_tick, proc_clk_tick, master_clk_tick;
logic [11:0] pll_mul_factor;
int n_fail = 0, cmp_count = 0, cyc = 0;
wire logic [4:0] tk = {pll_ref_tick, prog_clk_tick, master_clk_tick, proc_clk_tick};
clock_generator_config clock_generator_config_inst (.*);
always #10 aclk = ~aclk;
// Slow, main and PLL pins at 8, 4 and 16 cycles per period
always @(posedge aclk) begin
    cyc <= cyc + 1;
    slow_clk_pin <= cyc[2];
    main_clk_pin <= cyc[1];
    pll_clk_pin <= cyc[3];
end
task end_sim;
    if (n_fail == 0 && cmp_count > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask
task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
        n_fail++;
        $display("ERROR %0t got %h exp %h", $time, g, e);
    end
endtask
// One bus transfer; answer ready stands from the request until the answer
task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic at, wt, av, v;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    s_axi_bready <= w;
    s_axi_rready <= !w;
    for (int i = 0; i < 40; i++) begin
        @(negedge aclk);
        at = s_axi_awready;
        wt = s_axi_wready;
        av = s_axi_arready;
        v = w ? s_axi_bvalid : s_axi_rvalid;
        r = w ? s_axi_bresp : s_axi_rresp;
        q = s_axi_rdata;
        @(posedge aclk);
        if (at) s_axi_awvalid <= 0;
        if (wt) s_axi_wvalid <= 0;
        if (av) s_axi_arvalid <= 0;
        if (v) begin
            s_axi_bready <= 0;
            s_axi_rready <= 0;
            @(negedge aclk);
            return;
        end
    end
    n_fail++;
    end_sim;
endtask
task wr(input logic [7:0] a, input logic [31:0] d);
    axi(1, a, d);
    chk(r, `RESP_OKAY);
endtask
task rd(input logic [7:0] a, input logic [31:0] e);
    axi(0, a, 0);
    chk(q, e);
    chk(r, `RESP_OKAY);
endtask
// Poll status until the masked bits match, then judge the elapsed cycles
task automatic poll(input logic [7:0] m, input logic [7:0] e, input int lo, input int hi);
    int t0 = cyc;
    for (int i = 0; i < 400; i++) begin
        axi(0, `OFS_CLK_STATUS, 0);
        if ((q[7:0] & m) === e) begin
            chk(cyc - t0 >= lo && cyc - t0 <= hi, 1);
            return;
        end
    end
    chk(q[7:0] & m, e);
endtask
// Cycles between two pulses of the selected tick output
task automatic gap(input int s, input int e);
    int t = 0;
    for (int i = 0; i < 600; i++) begin
        @(negedge aclk);
        if (tk[s] && t > 0) begin
            chk(cyc - t, e);
            return;
        end
        if (tk[s]) t = cyc;
    end
    chk(0, e);
endtask
task t_reset;
    logic [7:0] a [8] = '{8'h1c, 8'h20, 8'h24, 8'h28, 8'h30, 8'h40, 8'h44, 8'h68};
    logic [31:0] e [8] = '{0, 0, 0, 32'h3f00, 0, 0, 0, 32'h8};
    foreach (a[i]) rd(a[i], e[i]);
endtask
task t_ro;
    @(posedge aclk);
    periph_clock_bit <= 32'ha5a5a5a7;
    rd(8'h18, 32'ha5a5a5a4);
    wr(8'h18, 0);
    wr(8'h24, 32'hffff);
    rd(8'h18, 32'ha5a5a5a4);
    rd(8'h24, 0);
    axi(0, 8'h2c, 0);
    chk(q, 0);
    chk(r, `RESP_SLVERR);
endtask
task t_osc;
    wr(8'h20, 32'h2);
    chk(main_osc_bypass, 1);
    rd(8'h68, 32'h9);
    wr(8'h20, 0);
    rd(8'h68, 32'h8);
    wr(8'h20, 32'h101);
    chk(main_osc_enable, 1);
    poll(8'h1, 8'h1, 56, 80);
    repeat (160) @(posedge aclk);
    rd(8'h24, 32'h10020);
    wr(8'h20, 0);
    rd(8'h24, 0);
endtask
task t_usb;
    wr(8'h1c, 32'h00110000);
    chk(usb_pll_enable, 1);
    rd(8'h68, 32'h8);
    poll(8'h40, 8'h40, 56, 80);
    wr(8'h1c, 32'h21110000);
    chk({usb_hs_allowed, usb_bias_enable}, 2'b11);
    chk(usb_bias_ready, 0);
    repeat (40) @(posedge aclk);
    chk(usb_bias_ready, 1);
    wr(8'h1c, 0);
    rd(8'h68, 32'h8);
endtask
task t_pll;
    wr(8'h28, 32'h00038402);
    rd(8'h28, 32'h00038402);
    chk({pll_enable, pll_freq_range, pll_mul_factor}, {1'b1, 2'h2, 12'h4});
    poll(8'h2, 8'h2, 24, 48);
    gap(4, 8);
    wr(8'h28, 32'h00030001);
    gap(4, 4);
    wr(8'h28, 32'h00030000);
    gap(4, 0);
    wr(8'h28, 32'h00038402);
    rd(8'h68, 32'h8);
    wr(8'h28, 32'h3f00);
    rd(8'h68, 32'h8);
    chk(pll_enable, 0);
endtask
task t_clk;
    wr(8'h30, 32'h105);
    poll(8'h8, 8'h8, 0, 40);
    gap(0, 8);
    gap(1, 16);
    wr(8'h30, 32'h201);
    gap(0, 4);
    gap(1, 16);
    wr(8'h40, 32'h8);
    gap(2, 32);
    wr(8'h44, 32'h2);
    gap(3, 16);
endtask
initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    t_reset;
    t_ro;
    t_osc;
    t_usb;
    t_pll;
    t_clk;
    end_sim;
end
endmodule
`default_nettype wire
